// File: core/owpt_pkg.sv
// package for the one-shot / wait one-shot pulse timer
// assumes a single 125 MHz clock and an Avalon-MM register slave
package owpt_pkg;
    localparam int OWPT_CLK_MHZ = 125;
    localparam int OWPT_ADDR_W = 5;
    localparam int OWPT_CNT_W = 8;

    // byte offsets of the register words
    localparam logic [4:0] OWPT_CTRL_OFS = 5'h00;
    localparam logic [4:0] OWPT_ONESHOT_OFS = 5'h04;
    localparam logic [4:0] OWPT_IOCTL_OFS = 5'h08;
    localparam logic [4:0] OWPT_MODE_OFS = 5'h0C;
    localparam logic [4:0] OWPT_PRESCALER_OFS = 5'h10;
    localparam logic [4:0] OWPT_PRIMARY_OFS = 5'h14;
    localparam logic [4:0] OWPT_SECONDARY_OFS = 5'h18;
    localparam logic [4:0] OWPT_STATUS_OFS = 5'h1C;

    // timer_control_reg
    localparam int OWPT_START_BIT = 0;
    localparam int OWPT_FSTOP_BIT = 1;
    localparam int OWPT_CSTAT_BIT = 2;
    // oneshot_control_reg
    localparam int OWPT_OS_START_BIT = 0;
    localparam int OWPT_OS_STOP_BIT = 1;
    localparam int OWPT_OS_ACTIVE_BIT = 2;
    // timer_io_control_reg
    localparam int OWPT_OUTLVL_BIT = 0;
    localparam int OWPT_EDGESEL_BIT = 1;
    localparam int OWPT_TRIGEN_BIT = 2;
    localparam int OWPT_BOTHEDGE_BIT = 3;
    localparam int OWPT_IRQPOL_BIT = 4;
    // timer_mode_reg
    localparam int OWPT_MODE_LSB = 0;
    localparam int OWPT_SRC_LSB = 4;
    // status word
    localparam int OWPT_PINIRQ_BIT = 0;

    localparam logic [7:0] OWPT_PRE_RST = 8'hFF;
    localparam logic [7:0] OWPT_PRI_RST = 8'hFF;
    localparam logic [7:0] OWPT_SEC_RST = 8'hFF;
    localparam logic [2:0] OWPT_F8_LAST = 3'h7;

    typedef enum logic [1:0] {
        OWPT_M_TIMER = 2'h0,
        OWPT_M_WAVE = 2'h1,
        OWPT_M_ONESHOT = 2'h2,
        OWPT_M_WAIT = 2'h3
    } owpt_mode_type;

    typedef enum logic [1:0] {
        OWPT_SRC_F1 = 2'h0,
        OWPT_SRC_F2 = 2'h1,
        OWPT_SRC_F8 = 2'h2,
        OWPT_SRC_UNDER = 2'h3
    } owpt_src_type;

    typedef enum logic [2:0] {
        OWPT_PH_IDLE = 3'h1,
        OWPT_PH_PRI = 3'h2,
        OWPT_PH_SEC = 3'h4
    } owpt_phase_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } owpt_avs_req_type;

    typedef struct packed {
        logic [2:0] csDiv;
        logic startBit;
        logic startSync;
        logic statusFlag;
        logic [1:0] trigStage;
        logic stopPend;
        logic active;
        owpt_phase_type phase;
        owpt_mode_type mode;
        owpt_src_type srcSel;
        logic outLevel;
        logic edgeSel;
        logic trigEn;
        logic bothEdge;
        logic irqPol;
        logic [7:0] preRld;
        logic [7:0] priRld;
        logic [7:0] secRld;
        logic [7:0] preCnt;
        logic [7:0] mainCnt;
        logic pinPrev;
        logic pinIrq;
        logic timerIrq;
        logic pulse;
        logic ack;
        logic [7:0] rdata;
    } owpt_state_type;
endpackage

// File: core/owpt_timer.sv
// 8-bit prescaled timer with one-shot and wait one-shot pulse modes
// assumes Avalon-MM master on the same clock; trigger pin already synchronous
`timescale 1ns/1ps
module owpt_timer
    import owpt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire owpt_avs_req_type avsReq,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input wire logic extTriggerPin,
    input wire logic otherUnderflow,
    output logic pulseOutputPin,
    output logic timerIrq,
    output logic pinIrqFlag
);
    owpt_state_type s_ff;
    owpt_state_type nxt_s;

    function automatic logic regHit(input logic [4:0] addr, input logic [4:0] ofs);
        regHit = (addr == ofs);
    endfunction

    logic busReq;
    logic wrEn;
    logic wrLow;
    logic csTick;
    logic oneshotMode;
    logic counting;
    logic preUnder;
    logic mainUnder;
    logic pinRise;
    logic pinFall;
    logic pinTrig;
    logic pinIrqEdge;
    logic swTrig;
    logic trigAccept;
    logic forceStop;
    logic [7:0] wByte;

    assign busReq = avsReq.read | avsReq.write;
    assign wrEn = avsReq.write & s_ff.ack;
    assign wrLow = wrEn & avsReq.byteenable[0];
    assign wByte = avsReq.writedata[7:0];
    assign oneshotMode = (s_ff.mode == OWPT_M_ONESHOT) || (s_ff.mode == OWPT_M_WAIT);
    assign avsWaitRequest = busReq & ~s_ff.ack;
    assign avsReadData = {24'h000000, s_ff.rdata};
    assign pulseOutputPin = s_ff.pulse ^ s_ff.outLevel;
    assign timerIrq = s_ff.timerIrq;
    assign pinIrqFlag = s_ff.pinIrq;

    always_comb begin
        case (s_ff.srcSel)
            OWPT_SRC_F1: csTick = 1'b1;
            OWPT_SRC_F2: csTick = s_ff.csDiv[0];
            OWPT_SRC_F8: csTick = (s_ff.csDiv == OWPT_F8_LAST);
            OWPT_SRC_UNDER: csTick = otherUnderflow;
            default: csTick = 1'b0;
        endcase
    end

    // no count on the tick a pending stop resolves, or the decrement would spoil the reload
    assign counting = s_ff.statusFlag && (s_ff.phase != OWPT_PH_IDLE) && (!oneshotMode || s_ff.active)
        && !s_ff.stopPend;
    assign preUnder = csTick && counting && (s_ff.preCnt == 8'h00);
    assign mainUnder = preUnder && (s_ff.mainCnt == 8'h00);

    assign pinRise = extTriggerPin & ~s_ff.pinPrev;
    assign pinFall = ~extTriggerPin & s_ff.pinPrev;
    assign pinTrig = s_ff.bothEdge ? (pinRise | pinFall) : (s_ff.edgeSel ? pinRise : pinFall);
    assign pinIrqEdge = s_ff.bothEdge ? (pinRise | pinFall) : (s_ff.irqPol ? pinRise : pinFall);
    assign swTrig = wrLow && regHit(avsReq.address, OWPT_ONESHOT_OFS) && wByte[OWPT_OS_START_BIT];
    assign forceStop = wrLow && regHit(avsReq.address, OWPT_CTRL_OFS) && wByte[OWPT_FSTOP_BIT];
    // the pin only triggers when enabled; otherwise it is a plain interrupt input
    assign trigAccept = (swTrig || (s_ff.trigEn && pinTrig)) && oneshotMode
        && s_ff.statusFlag && !s_ff.active && (s_ff.trigStage == 2'b00);

    always_comb begin
        nxt_s = s_ff;
        nxt_s.csDiv = s_ff.csDiv + 3'h1;
        nxt_s.pinPrev = extTriggerPin;
        nxt_s.timerIrq = 1'b0;
        nxt_s.ack = busReq & ~s_ff.ack;

        // status flag lags the start bit by two count-source ticks
        if (csTick) begin
            nxt_s.startSync = s_ff.startBit;
            nxt_s.statusFlag = s_ff.startSync;
        end
        if (!oneshotMode && nxt_s.statusFlag && s_ff.phase == OWPT_PH_IDLE) begin
            nxt_s.phase = OWPT_PH_PRI;
        end

        // trigger and stop requests resolve on ticks, a stop wins over a pending start
        if (csTick && s_ff.trigStage[1]) begin
            nxt_s.active = 1'b1;
            nxt_s.phase = OWPT_PH_PRI;
            nxt_s.trigStage = 2'b00;
        end else if (csTick) begin
            nxt_s.trigStage = {s_ff.trigStage[0], 1'b0};
        end
        if (trigAccept) begin
            nxt_s.trigStage = 2'b01;
        end
        if (csTick && s_ff.stopPend) begin
            nxt_s.stopPend = 1'b0;
            nxt_s.trigStage = 2'b00;
            nxt_s.active = 1'b0;
            nxt_s.phase = OWPT_PH_IDLE;
            nxt_s.preCnt = s_ff.preRld;
            nxt_s.mainCnt = s_ff.priRld;
        end

        // count: prescaler per tick, main counter per prescaler underflow
        if (csTick && counting) begin
            if (s_ff.preCnt != 8'h00) begin
                nxt_s.preCnt = s_ff.preCnt - 8'h01;
            end else begin
                nxt_s.preCnt = s_ff.preRld;
                if (s_ff.mainCnt != 8'h00) begin
                    nxt_s.mainCnt = s_ff.mainCnt - 8'h01;
                end else begin
                    case (s_ff.mode)
                        OWPT_M_TIMER: begin
                            nxt_s.mainCnt = s_ff.priRld;
                            nxt_s.timerIrq = 1'b1;
                        end
                        OWPT_M_WAVE: begin
                            if (s_ff.phase == OWPT_PH_PRI) begin
                                nxt_s.phase = OWPT_PH_SEC;
                                nxt_s.mainCnt = s_ff.secRld;
                            end else begin
                                nxt_s.phase = OWPT_PH_PRI;
                                nxt_s.mainCnt = s_ff.priRld;
                                nxt_s.timerIrq = 1'b1;
                            end
                        end
                        OWPT_M_ONESHOT: begin
                            nxt_s.mainCnt = s_ff.priRld;
                            nxt_s.active = 1'b0;
                            nxt_s.phase = OWPT_PH_IDLE;
                            nxt_s.timerIrq = 1'b1;
                        end
                        OWPT_M_WAIT: begin
                            if (s_ff.phase == OWPT_PH_PRI) begin
                                nxt_s.phase = OWPT_PH_SEC;
                                nxt_s.mainCnt = s_ff.secRld;
                            end else begin
                                nxt_s.phase = OWPT_PH_IDLE;
                                nxt_s.mainCnt = s_ff.priRld;
                                nxt_s.active = 1'b0;
                                nxt_s.timerIrq = 1'b1;
                            end
                        end
                        default: nxt_s.phase = OWPT_PH_IDLE;
                    endcase
                end
            end
        end

        // status flag falling in one-shot modes: live count is dropped
        if (s_ff.statusFlag && !nxt_s.statusFlag && oneshotMode) begin
            nxt_s.active = 1'b0;
            nxt_s.trigStage = 2'b00;
            nxt_s.phase = OWPT_PH_IDLE;
            nxt_s.preCnt = s_ff.preRld;
            nxt_s.mainCnt = s_ff.priRld;
        end

        // register writes, taken on the edge where waitrequest is low
        if (wrLow) begin
            if (regHit(avsReq.address, OWPT_CTRL_OFS)) begin
                nxt_s.startBit = wByte[OWPT_START_BIT];
            end
            if (regHit(avsReq.address, OWPT_ONESHOT_OFS) && wByte[OWPT_OS_STOP_BIT]
                    && (s_ff.active || s_ff.trigStage != 2'b00)) begin
                nxt_s.stopPend = 1'b1;
            end
            if (regHit(avsReq.address, OWPT_IOCTL_OFS)) begin
                nxt_s.outLevel = wByte[OWPT_OUTLVL_BIT];
                nxt_s.edgeSel = wByte[OWPT_EDGESEL_BIT];
                nxt_s.trigEn = wByte[OWPT_TRIGEN_BIT];
                nxt_s.bothEdge = wByte[OWPT_BOTHEDGE_BIT];
                nxt_s.irqPol = wByte[OWPT_IRQPOL_BIT];
            end
            if (regHit(avsReq.address, OWPT_MODE_OFS)) begin
                nxt_s.mode = owpt_mode_type'(wByte[OWPT_MODE_LSB +: 2]);
                nxt_s.srcSel = owpt_src_type'(wByte[OWPT_SRC_LSB +: 2]);
            end
            if (regHit(avsReq.address, OWPT_PRESCALER_OFS)) begin
                nxt_s.preRld = wByte;
                if (!s_ff.statusFlag) begin
                    nxt_s.preCnt = wByte;
                end
            end
            if (regHit(avsReq.address, OWPT_PRIMARY_OFS)) begin
                nxt_s.priRld = wByte;
                if (!s_ff.statusFlag) begin
                    nxt_s.mainCnt = wByte;
                end
            end
            if (regHit(avsReq.address, OWPT_SECONDARY_OFS)) begin
                nxt_s.secRld = wByte;
            end
            if (regHit(avsReq.address, OWPT_STATUS_OFS) && wByte[OWPT_PINIRQ_BIT]) begin
                nxt_s.pinIrq = 1'b0;
            end
        end

        // forced stop bypasses the tick synchroniser
        if (forceStop) begin
            nxt_s.startBit = 1'b0;
            nxt_s.startSync = 1'b0;
            nxt_s.statusFlag = 1'b0;
            nxt_s.active = 1'b0;
            nxt_s.trigStage = 2'b00;
            nxt_s.stopPend = 1'b0;
            nxt_s.phase = OWPT_PH_IDLE;
            if (s_ff.mode == OWPT_M_WAVE && s_ff.phase == OWPT_PH_PRI) begin
                nxt_s.preRld = OWPT_PRE_RST;
                nxt_s.preCnt = OWPT_PRE_RST;
                nxt_s.priRld = OWPT_PRI_RST;
                nxt_s.mainCnt = OWPT_PRI_RST;
            end
        end

        // pin flag: a new edge wins over a software clear in the same cycle
        if (pinIrqEdge) begin
            nxt_s.pinIrq = 1'b1;
        end

        case (nxt_s.mode)
            OWPT_M_ONESHOT: nxt_s.pulse = nxt_s.active && nxt_s.phase == OWPT_PH_PRI;
            OWPT_M_WAIT: nxt_s.pulse = nxt_s.active && nxt_s.phase == OWPT_PH_SEC;
            OWPT_M_WAVE: nxt_s.pulse = nxt_s.statusFlag && nxt_s.phase == OWPT_PH_SEC;
            default: nxt_s.pulse = 1'b0;
        endcase

        // read data is latched in the waiting cycle, presented with waitrequest low
        nxt_s.rdata = 8'h00;
        case (avsReq.address)
            OWPT_CTRL_OFS: nxt_s.rdata = {5'h00, s_ff.statusFlag, 1'b0, s_ff.startBit};
            OWPT_ONESHOT_OFS: nxt_s.rdata = {5'h00, s_ff.active, 2'b00};
            OWPT_IOCTL_OFS: nxt_s.rdata = {3'h0, s_ff.irqPol, s_ff.bothEdge, s_ff.trigEn, s_ff.edgeSel,
                s_ff.outLevel};
            OWPT_MODE_OFS: nxt_s.rdata = {2'b00, s_ff.srcSel, 2'b00, s_ff.mode};
            OWPT_PRESCALER_OFS: nxt_s.rdata = s_ff.preCnt;
            OWPT_PRIMARY_OFS: nxt_s.rdata = s_ff.mainCnt;
            OWPT_SECONDARY_OFS: nxt_s.rdata = s_ff.secRld;
            OWPT_STATUS_OFS: nxt_s.rdata = {7'h00, s_ff.pinIrq};
            default: nxt_s.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_ff <= '{csDiv: 3'h0, startBit: 1'b0, startSync: 1'b0, statusFlag: 1'b0,
                trigStage: 2'b00, stopPend: 1'b0, active: 1'b0, phase: OWPT_PH_IDLE,
                mode: OWPT_M_TIMER, srcSel: OWPT_SRC_F1, outLevel: 1'b0, edgeSel: 1'b0,
                trigEn: 1'b0, bothEdge: 1'b0, irqPol: 1'b0, preRld: OWPT_PRE_RST,
                priRld: OWPT_PRI_RST, secRld: OWPT_SEC_RST, preCnt: OWPT_PRE_RST,
                mainCnt: OWPT_PRI_RST, pinPrev: 1'b0, pinIrq: 1'b0, timerIrq: 1'b0,
                pulse: 1'b0, ack: 1'b0, rdata: 8'h00};
        end else begin
            s_ff <= nxt_s;
        end
    end

    a_start_needs_status: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(s_ff.active) |-> $past(s_ff.statusFlag))
        else $error("one-shot went active while count stopped");

    a_no_retrigger: assert property (@(posedge clk) disable iff (sys_rst)
        s_ff.active && swTrig |=> s_ff.trigStage == 2'b00)
        else $error("trigger accepted during active one-shot");

    a_trig_lag: assert property (@(posedge clk) disable iff (sys_rst)
        trigAccept && !forceStop |=> !s_ff.active && s_ff.trigStage == 2'b01)
        else $error("active flag set without lag");

    a_pin_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
        pinIrqEdge |=> s_ff.pinIrq)
        else $error("pin edge lost from irq flag");

    a_wait_secondary: assert property (@(posedge clk) disable iff (sys_rst)
        mainUnder && s_ff.mode == OWPT_M_WAIT && s_ff.phase == OWPT_PH_PRI && !forceStop && !wrEn
        |=> s_ff.phase == OWPT_PH_SEC && s_ff.mainCnt == $past(s_ff.secRld))
        else $error("secondary not loaded after wait");

    a_pulse_end_irq: assert property (@(posedge clk) disable iff (sys_rst)
        mainUnder && s_ff.mode == OWPT_M_WAIT && s_ff.phase == OWPT_PH_SEC && !forceStop
        |=> !s_ff.active && s_ff.timerIrq && s_ff.pulse == 1'b0)
        else $error("pulse end, irq and active flag out of step");

    a_force_stop: assert property (@(posedge clk) disable iff (sys_rst)
        forceStop |=> !s_ff.statusFlag && !s_ff.active && !counting)
        else $error("forced stop not immediate");

    a_reset_stopped: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> !s_ff.statusFlag && !s_ff.active && !s_ff.pulse)
        else $error("timer running after reset");

    a_stopped_load: assert property (@(posedge clk) disable iff (sys_rst)
        wrLow && regHit(avsReq.address, OWPT_PRESCALER_OFS) && !s_ff.statusFlag && !forceStop
        |=> s_ff.preCnt == $past(wByte))
        else $error("stopped write did not load counter");

    a_status_lag: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(s_ff.startBit) && !s_ff.statusFlag |-> !s_ff.statusFlag ##1 !s_ff.statusFlag)
        else $error("status flag followed start bit without lag");

    a_stop_reload: assert property (@(posedge clk) disable iff (sys_rst)
        csTick && s_ff.stopPend && !forceStop && !wrEn |=> !s_ff.active && s_ff.mainCnt == $past(s_ff.priRld))
        else $error("stop did not reload counter");

    a_irq_at_end: assert property (@(posedge clk) disable iff (sys_rst)
        s_ff.timerIrq && s_ff.mode == OWPT_M_WAIT |-> !s_ff.pulse && $past(s_ff.pulse))
        else $error("irq not at pulse end");

    a_prescale_step: assert property (@(posedge clk) disable iff (sys_rst)
        csTick && counting && s_ff.startSync && s_ff.preCnt != 8'h00 && !forceStop && !wrEn
        |=> s_ff.preCnt == $past(s_ff.preCnt) - 8'h01)
        else $error("prescaler did not step");

    a_fall_reload: assert property (@(posedge clk) disable iff (sys_rst)
        csTick && s_ff.statusFlag && !s_ff.startSync && oneshotMode && !forceStop
        |=> !s_ff.active && s_ff.mainCnt == $past(s_ff.priRld))
        else $error("start clear did not reload counter");

    a_pin_gated: assert property (@(posedge clk) disable iff (sys_rst)
        pinTrig && !s_ff.trigEn && !swTrig && s_ff.trigStage == 2'b00 |=> s_ff.trigStage == 2'b00)
        else $error("pin triggered while disabled");

    c_wait_pulse: cover property (@(posedge clk) disable iff (sys_rst)
        s_ff.mode == OWPT_M_WAIT && s_ff.timerIrq);
    c_pin_trigger: cover property (@(posedge clk) disable iff (sys_rst)
        trigAccept && !swTrig);
    c_force_wave: cover property (@(posedge clk) disable iff (sys_rst)
        forceStop && s_ff.mode == OWPT_M_WAVE && s_ff.phase == OWPT_PH_PRI);
    c_retrig_ignored: cover property (@(posedge clk) disable iff (sys_rst)
        s_ff.active && (swTrig || (s_ff.trigEn && pinTrig)));
    c_stop_resolve: cover property (@(posedge clk) disable iff (sys_rst)
        csTick && s_ff.stopPend);
endmodule

// File: test/owpt_far_side.sv
// far-side model: trigger source on the pin and the other timer's underflow
// assumes the bench sets pinLevel and underPeriod; one clock domain
`timescale 1ns/1ps
module owpt_far_side (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pinLevel,
    input wire logic [3:0] underPeriod,
    output logic extTriggerPin,
    output logic otherUnderflow
);
    // initial values keep the pin defined before the first edge
    logic pin_ff = 1'b0;
    logic under_ff = 1'b0;
    logic [3:0] div_ff = 4'h0;
    assign extTriggerPin = pin_ff;
    assign otherUnderflow = under_ff;
    always @(posedge clk) begin
        if (sys_rst) begin
            pin_ff <= 1'b0;
            under_ff <= 1'b0;
            div_ff <= 4'h0;
        end else begin
            pin_ff <= pinLevel;
            under_ff <= (div_ff == underPeriod - 4'h1);
            div_ff <= (div_ff == underPeriod - 4'h1) ? 4'h0 : div_ff + 4'h1;
        end
    end
endmodule

// File: test/owpt_timer_tb_top.sv
// self-checking bench for the one-shot / wait one-shot pulse timer
// assumes owpt_pkg, owpt_timer and owpt_far_side are compiled first
`timescale 1ns/1ps
module owpt_timer_tb_top;
    import owpt_pkg::*;
    localparam int UNDER_PERIOD = 5;
    logic clk;
    logic sysRst;
    owpt_avs_req_type avsReq;
    logic [31:0] avsReadData;
    logic avsWaitRequest;
    logic extTriggerPin;
    logic otherUnderflow;
    logic pulseOutputPin;
    logic timerIrq;
    logic pinIrqFlag;
    logic pinLevel;
    logic [3:0] underPeriod;
    logic outLvl;
    int err_total;
    int cmp_count;
    int cycleCount;

    owpt_timer i_owpt_timer (.clk(clk), .sys_rst(sysRst), .avsReq(avsReq), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .extTriggerPin(extTriggerPin), .otherUnderflow(otherUnderflow),
        .pulseOutputPin(pulseOutputPin), .timerIrq(timerIrq), .pinIrqFlag(pinIrqFlag));
    owpt_far_side i_owpt_far_side (.clk(clk), .sys_rst(sysRst), .pinLevel(pinLevel),
        .underPeriod(underPeriod), .extTriggerPin(extTriggerPin), .otherUnderflow(otherUnderflow));

    always #4 clk = ~clk;
    // a hang ends the run through the same report
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == 40000) begin
            err_total++;
            close_out;
        end
    end

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [4:0] adr, input logic [7:0] dat, output logic [7:0] q);
        @(posedge clk);
        avsReq.read <= !wr;
        avsReq.write <= wr;
        avsReq.address <= adr;
        avsReq.writedata <= {24'h000000, dat};
        avsReq.byteenable <= 4'hF;
        do begin
            @(posedge clk);
        end while (avsWaitRequest !== 1'b0);
        q = avsReadData[7:0];
        avsReq.read <= 1'b0;
        avsReq.write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask

    task automatic poll(input logic [4:0] a, input int b, input logic v);
        logic [7:0] q;
        int n;
        n = 0;
        do begin
            rd(a, q);
            n++;
        end while (q[b] !== v && n < 40);
        chk(q[b], v);
    endtask

    task automatic setup(input logic [1:0] src, input logic [7:0] pre, pri, sec, input logic [4:0] io);
        wr(OWPT_CTRL_OFS, 8'h00);
        poll(OWPT_CTRL_OFS, OWPT_CSTAT_BIT, 1'b0);
        wr(OWPT_MODE_OFS, {2'b00, src, 2'b00, 2'b11});
        wr(OWPT_IOCTL_OFS, {3'b000, io & 5'h1B});
        wr(OWPT_IOCTL_OFS, {3'b000, io});
        wr(OWPT_PRESCALER_OFS, pre);
        wr(OWPT_PRIMARY_OFS, pri);
        wr(OWPT_SECONDARY_OFS, sec);
        wr(OWPT_CTRL_OFS, 8'h01);
        poll(OWPT_CTRL_OFS, OWPT_CSTAT_BIT, 1'b1);
        wr(OWPT_STATUS_OFS, 8'h01);
        outLvl = io[0];
    endtask

    // cycles until the pulse starts and how long it stays active
    task automatic measure(input int limit, output int rise, output int width);
        rise = 0;
        width = 0;
        while (pulseOutputPin !== !outLvl && rise < limit) begin
            @(posedge clk);
            rise++;
        end
        if (rise < limit) begin
            while (pulseOutputPin === !outLvl && width < 2000) begin
                @(posedge clk);
                width++;
            end
            chk(timerIrq, 1'b1);
        end
    endtask

    task automatic t_reset;
        logic [7:0] q;
        for (int i = 0; i < 3; i++) begin
            rd(OWPT_PRESCALER_OFS + 5'(4 * i), q);
            chk(q, OWPT_PRE_RST);
        end
        rd(OWPT_CTRL_OFS, q);
        chk(q[2:0], 3'h0);
        chk({pulseOutputPin, timerIrq, pinIrqFlag}, 3'h0);
    endtask

    task automatic t_idle;
        logic [7:0] q;
        int r;
        int w;
        outLvl = 1'b0;
        wr(OWPT_MODE_OFS, 8'h03);
        wr(OWPT_ONESHOT_OFS, 8'h01);
        measure(60, r, w);
        chk(w, 0);
        rd(OWPT_ONESHOT_OFS, q);
        chk(q[OWPT_OS_ACTIVE_BIT], 1'b0);
    endtask

    task automatic t_sources;
        int divT[4] = '{1, 2, 8, UNDER_PERIOD};
        logic [7:0] q;
        int r;
        int w;
        for (int s = 0; s < 4; s++) begin
            setup(2'(s), 8'h01, 8'h02, 8'h03, 5'h00);
            wr(OWPT_ONESHOT_OFS, 8'h01);
            measure(500, r, w);
            chk(w, 8 * divT[s]);
            chk(r >= 6 * divT[s] && r <= 10 * divT[s] + 4, 1'b1);
            rd(OWPT_ONESHOT_OFS, q);
            chk(q[OWPT_OS_ACTIVE_BIT], 1'b0);
            rd(OWPT_PRIMARY_OFS, q);
            chk(q, 8'h02);
        end
        setup(2'h0, 8'h01, 8'h02, 8'h03, 5'h01);
        wr(OWPT_ONESHOT_OFS, 8'h01);
        measure(100, r, w);
        chk(w, 8);
        chk(pulseOutputPin, 1'b1);
    endtask

    task automatic t_retrig;
        int r;
        int w;
        setup(2'h0, 8'h01, 8'h14, 8'h03, 5'h16);
        wr(OWPT_ONESHOT_OFS, 8'h01);
        poll(OWPT_ONESHOT_OFS, OWPT_OS_ACTIVE_BIT, 1'b1);
        wr(OWPT_ONESHOT_OFS, 8'h01);
        @(posedge clk);
        pinLevel <= 1'b1;
        measure(200, r, w);
        chk(w, 8);
        chk(pinIrqFlag, 1'b1);
        measure(150, r, w);
        chk(w, 0);
    endtask

    task automatic t_pin;
        logic [4:0] ioT[6] = '{5'h16, 5'h04, 5'h16, 5'h12, 5'h0C, 5'h0C};
        logic fromT[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        logic pulseT[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        logic flagT[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        int r;
        int w;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            pinLevel <= fromT[i];
            setup(2'h0, 8'h01, 8'h02, 8'h03, ioT[i]);
            // the clear lands on the edge the write returns at; look one edge later
            @(posedge clk);
            chk(pinIrqFlag, 1'b0);
            @(posedge clk);
            pinLevel <= !fromT[i];
            measure(60, r, w);
            chk(w, pulseT[i] ? 8 : 0);
            chk(pinIrqFlag, flagT[i]);
        end
    endtask

    task automatic t_stop;
        logic [7:0] q;
        int r;
        int w;
        for (int k = 0; k < 2; k++) begin
            setup(2'h0, 8'h01, 8'h1E, 8'h03, 5'h00);
            wr(OWPT_ONESHOT_OFS, 8'h01);
            poll(OWPT_ONESHOT_OFS, OWPT_OS_ACTIVE_BIT, 1'b1);
            wr(k == 0 ? OWPT_ONESHOT_OFS : OWPT_CTRL_OFS, k == 0 ? 8'h02 : 8'h00);
            // during the status lag only the status flag may be touched
            if (k == 1) poll(OWPT_CTRL_OFS, OWPT_CSTAT_BIT, 1'b0);
            poll(OWPT_ONESHOT_OFS, OWPT_OS_ACTIVE_BIT, 1'b0);
            measure(120, r, w);
            chk(w, 0);
            rd(OWPT_PRIMARY_OFS, q);
            chk(q, 8'h1E);
        end
        // slow source so a synchronised stop would still show status
        setup(2'h2, 8'h01, 8'h1E, 8'h03, 5'h00);
        wr(OWPT_ONESHOT_OFS, 8'h01);
        poll(OWPT_ONESHOT_OFS, OWPT_OS_ACTIVE_BIT, 1'b1);
        wr(OWPT_CTRL_OFS, 8'h02);
        rd(OWPT_CTRL_OFS, q);
        chk(q[OWPT_CSTAT_BIT], 1'b0);
        measure(600, r, w);
        chk(w, 0);
        // waveform mode: forced stop inside the primary period restores the prescaler and primary reset values
        wr(OWPT_MODE_OFS, 8'h01);
        wr(OWPT_CTRL_OFS, 8'h01);
        poll(OWPT_CTRL_OFS, OWPT_CSTAT_BIT, 1'b1);
        wr(OWPT_CTRL_OFS, 8'h02);
        rd(OWPT_PRESCALER_OFS, q);
        chk(q, OWPT_PRE_RST);
        rd(OWPT_PRIMARY_OFS, q);
        chk(q, OWPT_PRI_RST);
    endtask

    task automatic t_reload;
        logic [7:0] q;
        int r;
        int w;
        setup(2'h0, 8'h01, 8'h40, 8'h03, 5'h00);
        rd(OWPT_PRIMARY_OFS, q);
        chk(q, 8'h40);
        wr(OWPT_PRIMARY_OFS, 8'h50);
        rd(OWPT_PRIMARY_OFS, q);
        chk(q, 8'h40);
        wr(OWPT_ONESHOT_OFS, 8'h01);
        measure(400, r, w);
        chk(w, 8);
        rd(OWPT_PRIMARY_OFS, q);
        chk(q, 8'h50);
    endtask

    initial begin
        clk = 1'b0;
        sysRst = 1'b1;
        avsReq = '0;
        pinLevel = 1'b0;
        underPeriod = 4'(UNDER_PERIOD);
        outLvl = 1'b0;
        err_total = 0;
        cmp_count = 0;
        cycleCount = 0;
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        t_reset;
        t_idle;
        t_sources;
        t_retrig;
        t_pin;
        t_stop;
        t_reload;
        close_out;
    end
endmodule
